// >>> hw/adc_config_register_access.sv
// register bank and command decode behind the serial link
//
// Summary of operation
// - each register is either read-write or read-only
// - writes to the read-only flag register are discarded
// - writes to unimplemented selects change nothing
// - reads of unimplemented selects leave next frame carrying conversions
// - a command frame is 16 serial clocks, msb first
// - top bit is write flag, next three select; low 12 bits load
// - a valid read returns register contents on the next access
// - read with select 0, 6 or 7 returns conversion results next
`timescale 1ns/1ps
module adc_config_register_access (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic primary_serial_output,
  // conversion result to send when no readback is pending
  input wire logic [15:0] conversion_word,
  // alert flags raised by the comparator logic
  input wire logic [15:0] flag_status_in,
  // register contents to the rest of the device
  output logic [15:0] device_setup_primary,
  output logic [15:0] output_lane_and_soft_reset,
  output logic [15:0] lower_limit_value,
  output logic [15:0] upper_limit_value,
  output logic readback_pending
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic [11:0] setup_primary;
    logic [11:0] output_lane;
    logic [11:0] flag_status;
    logic [11:0] lower_limit;
    logic [11:0] upper_limit;
    logic pending;
    logic [2:0] pending_sel;
    logic [15:0] answer;
  } bank_t;
  bank_t st, next_st;

  frame_link_if link ();

  // ----------------------------------------
  // register view with select in the top bits
  // ----------------------------------------
  function automatic logic [15:0] view(input bank_t s, input logic [2:0] sel);
    logic [11:0] body;
    body = 12'h000;
    case (sel)
      adc_reg_pkg::sel_setup_primary: body = s.setup_primary;
      adc_reg_pkg::sel_output_lane: body = s.output_lane;
      adc_reg_pkg::sel_flag_status: body = s.flag_status;
      adc_reg_pkg::sel_lower_limit: body = s.lower_limit;
      adc_reg_pkg::sel_upper_limit: body = s.upper_limit;
      default: body = 12'h000;
    endcase
    view = {1'b0, sel, body};
  endfunction

  // ----------------------------------------
  // access type of each select
  // ----------------------------------------
  typedef enum logic [1:0] {
    acc_none,
    acc_read_write,
    acc_read_only
  } access_t;

  function automatic access_t access_of(input logic [2:0] sel);
    case (sel)
      adc_reg_pkg::sel_setup_primary: access_of = acc_read_write;
      adc_reg_pkg::sel_output_lane: access_of = acc_read_write;
      adc_reg_pkg::sel_flag_status: access_of = acc_read_only;
      adc_reg_pkg::sel_lower_limit: access_of = acc_read_write;
      adc_reg_pkg::sel_upper_limit: access_of = acc_read_write;
      default: access_of = acc_none;
    endcase
  endfunction

  // only read-write selects take a write
  function automatic logic writable(input logic [2:0] sel);
    writable = (access_of(sel) == acc_read_write);
  endfunction

  // a select with no register reads back conversion results instead
  function automatic logic readable(input logic [2:0] sel);
    readable = (access_of(sel) == acc_read_write) ||
      (access_of(sel) == acc_read_only);
  endfunction

  // ----------------------------------------
  // writable bits of each register
  // ----------------------------------------
  function automatic logic [11:0] write_mask(input logic [2:0] sel);
    case (sel)
      adc_reg_pkg::sel_setup_primary:
        write_mask = adc_reg_pkg::mask_setup_primary;
      adc_reg_pkg::sel_output_lane:
        write_mask = adc_reg_pkg::mask_output_lane;
      adc_reg_pkg::sel_lower_limit: write_mask = adc_reg_pkg::mask_limit;
      adc_reg_pkg::sel_upper_limit: write_mask = adc_reg_pkg::mask_limit;
      default: write_mask = 12'h000;
    endcase
  endfunction

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic wr;
  logic [2:0] register_select;
  logic [11:0] data;
  assign wr = link.command[adc_reg_pkg::write_flag_pos];
  assign register_select =
    link.command[adc_reg_pkg::select_hi:adc_reg_pkg::select_lo];
  assign data = link.command[adc_reg_pkg::data_bits-1:0];
  logic take_write;
  logic take_read;
  logic [11:0] write_body;
  assign take_write = link.frame_done && wr && writable(register_select);
  assign take_read = link.frame_done && !wr && readable(register_select);
  assign write_body = data & write_mask(register_select);

  // ----------------------------------------
  // register update
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // link pins pass two flops before the shifter reads them
    next_st.sclk_sync = {st.sclk_sync[0], sclk};
    next_st.cs_sync = {st.cs_sync[0], cs_n};
    next_st.sdi_sync = {st.sdi_sync[0], sdi};
    // flags follow the comparator; reserved positions forced low
    next_st.flag_status = flag_status_in[11:0] &
      adc_reg_pkg::mask_flag_status[11:0];
    // a frame start consumes any pending readback
    if (link.frame_start) begin
      next_st.pending = 1'b0;
    end
    // any finished command decides what the next frame carries
    if (link.frame_done) begin
      next_st.pending = 1'b0;
    end
    if (take_write) begin
      case (register_select)
        adc_reg_pkg::sel_setup_primary:
          next_st.setup_primary = write_body;
        adc_reg_pkg::sel_output_lane:
          next_st.output_lane = write_body;
        adc_reg_pkg::sel_lower_limit:
          next_st.lower_limit = write_body;
        adc_reg_pkg::sel_upper_limit:
          next_st.upper_limit = write_body;
        // the read-only flag register never reaches here
        default: next_st.setup_primary = st.setup_primary;
      endcase
    end
    if (take_read) begin
      next_st.pending = 1'b1;
      next_st.pending_sel = register_select;
    end
    // word offered to the shifter at next frame open
    if (next_st.pending) begin
      next_st.answer = view(next_st, next_st.pending_sel);
    end else begin
      next_st.answer = conversion_word;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.cs_sync <= 2'b11;
      st.setup_primary <= adc_reg_pkg::rst_setup_primary[11:0];
      st.output_lane <= adc_reg_pkg::rst_output_lane[11:0];
      st.flag_status <= adc_reg_pkg::rst_flag_status[11:0];
      st.lower_limit <= adc_reg_pkg::rst_lower_limit[11:0];
      st.upper_limit <= adc_reg_pkg::rst_upper_limit[11:0];
      st.answer <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  assign link.load_word = st.answer;

  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  serial_shifter u_shifter (
    .core_clk(core_clk),
    .rstn(rstn),
    .sclk_s(st.sclk_sync[1]),
    .cs_n_s(st.cs_sync[1]),
    .sdi_s(st.sdi_sync[1]),
    .link(link),
    .primary_serial_output(primary_serial_output)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign device_setup_primary = view(st, adc_reg_pkg::sel_setup_primary);
  assign output_lane_and_soft_reset = view(st, adc_reg_pkg::sel_output_lane);
  assign lower_limit_value = view(st, adc_reg_pkg::sel_lower_limit);
  assign upper_limit_value = view(st, adc_reg_pkg::sel_upper_limit);
  assign readback_pending = st.pending;
endmodule

// >>> hw/adc_reg_pkg.sv
// constants and types for the serial register access block
package adc_reg_pkg;
  // ----------------------------------------
  // frame format
  // ----------------------------------------
  localparam int frame_bits = 16;
  localparam int write_flag_pos = 15;
  localparam int select_hi = 14;
  localparam int select_lo = 12;
  localparam int data_bits = 12;
  // ----------------------------------------
  // register selects
  // ----------------------------------------
  localparam logic [2:0] sel_setup_primary = 3'h1;
  localparam logic [2:0] sel_output_lane = 3'h2;
  localparam logic [2:0] sel_flag_status = 3'h3;
  localparam logic [2:0] sel_lower_limit = 3'h4;
  localparam logic [2:0] sel_upper_limit = 3'h5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] rst_setup_primary = 16'h0000;
  localparam logic [15:0] rst_output_lane = 16'h0000;
  localparam logic [15:0] rst_flag_status = 16'h0000;
  localparam logic [15:0] rst_lower_limit = 16'h0800;
  localparam logic [15:0] rst_upper_limit = 16'h07ff;
  // ----------------------------------------
  // writable bit masks within the low 12 bits, and the implemented flag bits
  // ----------------------------------------
  localparam logic [11:0] mask_setup_primary = 12'h3ff;
  localparam logic [11:0] mask_output_lane = 12'h1ff;
  localparam logic [11:0] mask_limit = 12'hfff;
  localparam logic [15:0] mask_flag_status = 16'h0333;
endpackage

// >>> hw/frame_link_if.sv
// carrier between serial shifter and register bank
`timescale 1ns/1ps
interface frame_link_if;
  logic frame_done;
  logic [15:0] command;
  logic frame_start;
  logic [15:0] load_word;
  modport shifter (output frame_done, output command, output frame_start,
    input load_word);
  modport bank (input frame_done, input command, input frame_start,
    output load_word);
endinterface

// >>> hw/serial_shifter.sv
// serial shifter: samples link pins, shifts command in, word out
`timescale 1ns/1ps
module serial_shifter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // link pins, already synchronised
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic sdi_s,
  // to the bank
  frame_link_if.shifter link,
  // serial data out
  output logic primary_serial_output
);
  typedef struct packed {
    logic sclk_d;
    logic cs_n_d;
    logic [4:0] count;
    logic [15:0] rx;
    logic [15:0] tx;
    logic done;
    logic start;
    logic sdo;
    logic [15:0] cmd;
  } sh_t;
  sh_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.sclk_d = sclk_s;
    next_st.cs_n_d = cs_n_s;
    next_st.done = 1'b0;
    next_st.start = 1'b0;
    if (st.cs_n_d && !cs_n_s) begin
      // frame opens: load answer word, first bit out
      next_st.count = 5'h00;
      next_st.start = 1'b1;
      next_st.tx = link.load_word;
      next_st.sdo = link.load_word[15];
    end else if (!cs_n_s) begin
      if (!st.sclk_d && sclk_s && st.count < 5'(adc_reg_pkg::frame_bits))
      begin
        // rising edge: take next bit, msb first
        next_st.rx = {st.rx[14:0], sdi_s};
        next_st.count = st.count + 5'h01;
        if (st.count == 5'(adc_reg_pkg::frame_bits - 1)) begin
          next_st.done = 1'b1;
          next_st.cmd = {st.rx[14:0], sdi_s};
        end
      end
      if (st.sclk_d && !sclk_s) begin
        next_st.tx = {st.tx[14:0], 1'b0};
        next_st.sdo = st.tx[14];
      end
    end
    if (cs_n_s) begin
      next_st.sdo = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.sclk_d <= 1'b0;
      st.cs_n_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.frame_done = st.done;
  assign link.frame_start = st.start;
  assign link.command = st.cmd;
  assign primary_serial_output = st.sdo;
endmodule

// >>> verification/adc_config_register_access_properties.sv
// checker for the serial register access block
`timescale 1ns/1ps
module adc_config_register_access_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // link
  input wire logic cs_n,
  input wire logic primary_serial_output,
  // registers
  input wire logic [15:0] device_setup_primary,
  input wire logic [15:0] output_lane_and_soft_reset,
  input wire logic [15:0] lower_limit_value,
  input wire logic [15:0] upper_limit_value,
  input wire logic readback_pending
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_setup_fixed_bits: assert property (
    device_setup_primary[15:10] == 6'h04)
    else $error("setup fixed bits wrong");
  a_lane_fixed_bits: assert property (
    output_lane_and_soft_reset[15:9] == 7'h10) else $error("lane bits wrong");
  a_lower_select: assert property (lower_limit_value[15:12] == 4'h4)
    else $error("lower select wrong");
  a_upper_select: assert property (upper_limit_value[15:12] == 4'h5)
    else $error("upper select wrong");
  a_reset_values: assert property ($rose(rstn) |->
    device_setup_primary == 16'h1000 && output_lane_and_soft_reset == 16'h2000
    && lower_limit_value == 16'h4800 && upper_limit_value == 16'h57ff
    && !readback_pending) else $error("reset values wrong");
  a_output_idle_low: assert property (
    cs_n [*5] |-> !primary_serial_output) else $error("output not idle");
  a_pending_drop: assert property ($fell(readback_pending) |-> !cs_n)
    else $error("pending dropped outside frame");
  a_idle_stable: assert property (cs_n [*8] |->
    $stable(device_setup_primary) && $stable(output_lane_and_soft_reset)
    && $stable(lower_limit_value) && $stable(upper_limit_value)
    && $stable(readback_pending)) else $error("state moved while idle");
  c_pending: cover property ($rose(readback_pending));
  c_write: cover property ($changed(lower_limit_value));
  c_frame: cover property (!cs_n [*8]);
endmodule
bind adc_config_register_access adc_config_register_access_properties chk (
  .core_clk, .rstn, .cs_n, .primary_serial_output, .device_setup_primary,
  .output_lane_and_soft_reset, .lower_limit_value, .upper_limit_value,
  .readback_pending);

// >>> verification/adc_config_register_access_tb.sv
// testbench for the serial register access block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module adc_config_register_access_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, cs_n, sdi, sdo, pending;
  logic [15:0] conv = 16'hc3a5;
  logic [15:0] flags = 16'hffff;
  logic [15:0] rd, setup, lane, lower, upper;
  logic [15:0] exp [1:5];
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  always #25 core_clk = ~core_clk;
  host_link_model host (.core_clk, .sclk, .cs_n, .sdi, .sdo);
  adc_config_register_access dut (.core_clk, .rstn, .sclk, .cs_n, .sdi,
    .primary_serial_output(sdo), .conversion_word(conv),
    .flag_status_in(flags), .device_setup_primary(setup),
    .output_lane_and_soft_reset(lane), .lower_limit_value(lower),
    .upper_limit_value(upper), .readback_pending(pending));
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  function automatic logic [11:0] wmask(input logic [2:0] s);
    case (s)
      3'h1: return 12'h3ff;
      3'h2: return 12'h1ff;
      default: return 12'hfff;
    endcase
  endfunction
  task automatic check_regs;
    `CHK("setup", exp[1], setup)
    `CHK("lane", exp[2], lane)
    `CHK("lower", exp[4], lower)
    `CHK("upper", exp[5], upper)
  endtask
  task automatic read_back(input logic [2:0] s, input logic [15:0] want,
      input logic pend);
    host.xfer({1'b0, s, 12'h000}, rd);
    `CHK("pending", pend, pending)
    host.xfer(16'h0000, rd);
    `CHK("readback", want, rd)
  endtask
  task automatic t_reset;
    exp = '{16'h1000, 16'h2000, 16'h3333, 16'h4800, 16'h57ff};
    check_regs();
    `CHK("pending", 1'b0, pending)
  endtask
  // selects 1..5; the flag register must refuse the write
  task automatic t_write_all(input logic [11:0] d);
    for (int i = 1; i <= 5; i++) begin
      host.xfer({1'b1, i[2:0], d}, rd);
      if (i != 3) exp[i] = {1'b0, i[2:0], d & wmask(i[2:0])};
    end
    check_regs();
    for (int i = 1; i <= 5; i++) read_back(i[2:0], exp[i], 1'b1);
  endtask
  task automatic t_bad_sel;
    logic [2:0] s [3] = '{3'h0, 3'h6, 3'h7};
    for (int i = 0; i < 3; i++) begin
      host.xfer({1'b1, s[i], 12'hfff}, rd);
      check_regs();
      read_back(s[i], conv, 1'b0);
    end
  endtask
  task automatic t_cancel;
    host.xfer(16'h1000, rd);
    host.xfer(16'hc123, rd);
    exp[4] = 16'h4123;
    `CHK("pending", 1'b0, pending)
    host.xfer(16'h0000, rd);
    `CHK("readback", conv, rd)
    check_regs();
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_write_all(12'hfff);
    t_write_all(12'ha5a);
    t_bad_sel();
    t_cancel();
    test_done();
  end
endmodule

// >>> verification/host_link_model.sv
// host-side serial master model driving command frames
`timescale 1ns/1ps
module host_link_model (
  // clock
  input wire logic core_clk,
  // link pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // one frame of 16 clocks, msb first; reply bit taken at each fall
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge core_clk) cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      sdi <= cmd[i];
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd[i] = sdo;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    // released line shows the inverse of its last bit
    sdi <= ~sdi;
    repeat (8) @(posedge core_clk);
  endtask
endmodule
